// ### rtl/ssf_flags.sv
// security status, join status and extended exception flags behind the command byte stream
`default_nettype none
module ssf_flags
  import ssf_pkg::*;
#(
  parameter int SEQ_W = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [7:0]       cmd_rx_byte,
  input  wire logic             cmd_rx_valid,
  output logic      [7:0]       cmd_tx_byte,
  output logic                  cmd_tx_valid,
  input  wire logic             cmd_tx_ready,
  input  wire ssf_event_t       events,
  input  wire logic             tx_sent,
  input  wire logic             tx_ack_required,
  input  wire logic             ack_received,
  input  wire logic             rx_data_arrived,
  input  wire logic             rx_all_drained,
  input  wire logic             rx_plaintext_pkt,
  input  wire logic             plaintext_receive_enable,
  input  wire logic             rx_encrypted_pkt,
  input  wire logic [SEQ_W-1:0] rx_seq_num,
  input  wire logic             join_start,
  input  wire logic             join_finished,
  input  wire logic             volatile_key_loaded,
  input  wire logic             nonvolatile_key_loaded,
  input  wire logic [7:0]       join_activity_code,
  input  wire logic [23:0]      ext_exception_enable_mask,
  input  wire logic [7:0]       basic_exception_enable_mask,
  output logic                  exception_status_line,
  output logic                  input_buffer_clear,
  output logic                  join_halt,
  output logic                  join_active
);

  ////////////////////////////////////////////////////////////////////////////
  ssf_state_t        state_r;
  logic [7:0]        size_r;
  logic [7:0]        addr_r;
  logic [7:0]        val_r;
  logic [15:0]       resp_r;
  logic [1:0]        resp_left_r;
  logic [23:0]       flags_r;
  logic [23:0]       flags_nxt;
  logic [23:0]       set_v;
  logic [23:0]       and_v;
  logic [SEQ_W-1:0]  prev_seq_r;
  logic              have_prev_r;
  logic              ack_wait_r;
  logic              rx_go;
  logic              rd_fire;
  logic              wr_fire;
  logic              wr_sub;
  logic [7:0]        wr_val;
  logic [7:0]        rd_addr;
  logic [7:0]        wr_addr;
  logic              rd_known;
  logic [7:0]        rd_value;
  logic              is_flag;
  logic              is_halt;
  logic              is_clear_input_buffer_cmd;
  logic              wr_ok;
  logic              reject_evt;
  logic              clear_input_buffer_cmd_evt;
  logic              tx_done_evt;
  logic              seq_back;
  logic              seq_gap;

  ////////////////////////////////////////////////////////////////////////////
  // command decode; bytes that arrive while an answer is going out are dropped
  assign rx_go    = cmd_rx_valid && state_r != ST_RESP;
  assign rd_fire  = rx_go && state_r == ST_RADDR;
  assign wr_fire  = rx_go && ((state_r == ST_WVAL && size_r != SSF_SIZE_SUB) || state_r == ST_WSUB);
  assign wr_sub   = state_r == ST_WSUB;
  assign wr_val   = wr_sub ? val_r : cmd_rx_byte;
  // the address byte names the volatile copy with bit 7 clear
  assign rd_addr  = cmd_rx_byte | SSF_VOL_BIT;
  assign wr_addr  = addr_r | SSF_VOL_BIT;
  assign is_flag  = !addr_r[7] && (wr_addr == SSF_ADDR_FHI || wr_addr == SSF_ADDR_FMID || wr_addr == SSF_ADDR_FLO);
  // an address byte with bit 7 set is refused for commands as for flags
  assign is_halt  = wr_sub && !addr_r[7] && wr_addr == SSF_ADDR_CMD && wr_val == SSF_CMD_JOIN &&
                    cmd_rx_byte == SSF_JOIN_HALT;
  assign is_clear_input_buffer_cmd = !wr_sub && !addr_r[7] && wr_addr == SSF_ADDR_CMD && wr_val == SSF_CMD_CLEAR_INPUT_BUFFER_CMD;
  assign wr_ok    = is_halt || ((is_flag || is_clear_input_buffer_cmd) && !join_active);
  assign reject_evt = wr_fire && !wr_ok;
  assign clear_input_buffer_cmd_evt  = wr_fire && wr_ok && is_clear_input_buffer_cmd;

  always_comb begin
    rd_known = !cmd_rx_byte[7];
    case (rd_addr)
      SSF_ADDR_SEC: begin
        rd_value = 8'h00;
        rd_value[SSF_SEC_VKEY_BIT]  = volatile_key_loaded;
        rd_value[SSF_SEC_NVKEY_BIT] = nonvolatile_key_loaded;
      end
      SSF_ADDR_JOIN: rd_value = join_activity_code;
      SSF_ADDR_FHI:  rd_value = flags_r[23:16];
      SSF_ADDR_FMID: rd_value = flags_r[15:8];
      SSF_ADDR_FLO:  rd_value = flags_r[7:0];
      default: begin
        rd_value = 8'h00;
        rd_known = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      size_r       <= 8'h00;
      addr_r       <= 8'h00;
      val_r        <= 8'h00;
      resp_r       <= 16'h0000;
      resp_left_r  <= 2'd0;
      cmd_tx_byte  <= 8'h00;
      cmd_tx_valid <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: if (cmd_rx_valid && cmd_rx_byte == SSF_HDR) state_r <= ST_SIZE;
        ST_SIZE: if (cmd_rx_valid) begin
          size_r  <= cmd_rx_byte;
          state_r <= ST_ESC;
        end
        ST_ESC: if (cmd_rx_valid) state_r <= (cmd_rx_byte == SSF_ESC) ? ST_KIND : ST_IDLE;
        ST_KIND: if (cmd_rx_valid) begin
          addr_r  <= cmd_rx_byte;
          state_r <= (cmd_rx_byte == SSF_ESC) ? ST_RADDR : ST_WVAL;
        end
        ST_RADDR: if (cmd_rx_valid) begin
          state_r      <= ST_RESP;
          cmd_tx_valid <= 1'b1;
          cmd_tx_byte  <= rd_known ? SSF_ACK : SSF_NACK;
          resp_r       <= {rd_addr, rd_value};
          resp_left_r  <= rd_known ? 2'd2 : 2'd0;
        end
        ST_WVAL: if (cmd_rx_valid) begin
          val_r <= cmd_rx_byte;
          if (size_r == SSF_SIZE_SUB) begin
            state_r <= ST_WSUB;
          end else begin
            state_r      <= ST_RESP;
            cmd_tx_valid <= 1'b1;
            cmd_tx_byte  <= wr_ok ? SSF_ACK : SSF_NACK;
            resp_left_r  <= 2'd0;
          end
        end
        ST_WSUB: if (cmd_rx_valid) begin
          state_r      <= ST_RESP;
          cmd_tx_valid <= 1'b1;
          cmd_tx_byte  <= wr_ok ? SSF_ACK : SSF_NACK;
          resp_left_r  <= 2'd0;
        end
        ST_RESP: if (cmd_tx_ready) begin
          if (resp_left_r == 2'd0) begin
            cmd_tx_valid <= 1'b0;
            state_r      <= ST_IDLE;
          end else begin
            cmd_tx_byte <= resp_r[15:8];
            resp_r      <= {resp_r[7:0], 8'h00};
            resp_left_r <= resp_left_r - 2'd1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halt completes in the same cycle the answer is loaded, so it precedes the ack
  always_ff @(posedge clock) begin
    if (rst) begin
      join_active        <= 1'b0;
      join_halt          <= 1'b0;
      input_buffer_clear <= 1'b0;
    end else begin
      join_halt          <= wr_fire && is_halt;
      input_buffer_clear <= clear_input_buffer_cmd_evt;
      if (join_start) join_active <= 1'b1;
      else if (join_finished || (wr_fire && is_halt)) join_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit completion waits for the ack when one was asked for
  assign tx_done_evt = (tx_sent && !tx_ack_required) || (ack_received && ack_wait_r);

  always_ff @(posedge clock) begin
    if (rst) ack_wait_r <= 1'b0;
    else if (tx_sent && tx_ack_required) ack_wait_r <= 1'b1;
    else if (ack_received) ack_wait_r <= 1'b0;
  end

  // the first packet after reset has nothing to compare against
  assign seq_back = rx_encrypted_pkt && have_prev_r && rx_seq_num < prev_seq_r;
  assign seq_gap  = rx_encrypted_pkt && have_prev_r &&
                    {1'b0, rx_seq_num} > ({1'b0, prev_seq_r} + {{SEQ_W{1'b0}}, 1'b1});

  always_ff @(posedge clock) begin
    if (rst) begin
      prev_seq_r  <= '0;
      have_prev_r <= 1'b0;
    end else if (rx_encrypted_pkt) begin
      prev_seq_r  <= rx_seq_num;
      have_prev_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    set_v = 24'h000000;
    set_v[7:0] = events;
    set_v[SSF_BIT_WRREJ]   = events.write_rejected || reject_evt;
    set_v[SSF_BIT_TXDONE]  = tx_done_evt;
    set_v[SSF_BIT_RXWAIT]  = rx_data_arrived;
    set_v[SSF_BIT_PLAIN]   = rx_plaintext_pkt && plaintext_receive_enable;
    set_v[SSF_BIT_SEQBACK] = seq_back;
    set_v[SSF_BIT_SEQGAP]  = seq_gap;
    set_v[SSF_BIT_JOIN]    = join_start;
    and_v = 24'hFFFFFF;
    if (wr_fire && wr_ok && is_flag) begin
      case (wr_addr)
        SSF_ADDR_FHI:  and_v[23:16] = wr_val;
        SSF_ADDR_FMID: and_v[15:8]  = wr_val;
        default:       and_v[7:0]   = wr_val;
      endcase
    end
    if (rx_all_drained || clear_input_buffer_cmd_evt) and_v[SSF_BIT_RXWAIT] = 1'b0;
    // set applied after the clear so a same-cycle event survives
    flags_nxt = ((flags_r & and_v) | set_v) & SSF_FLAG_IMPL;
  end

  always_ff @(posedge clock) begin
    if (rst) flags_r <= SSF_FLAG_RST;
    else flags_r <= flags_nxt;
  end

  always_ff @(posedge clock) begin
    if (rst) exception_status_line <= 1'b0;
    else exception_status_line <= |(flags_r & ext_exception_enable_mask) && basic_exception_enable_mask == 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_read_keeps;
    rd_fire && set_v == 24'h000000 && and_v == 24'hFFFFFF |=> flags_r == $past(flags_r);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("flag read altered flags");

  property p_and_low;
    wr_fire && wr_ok && wr_addr == SSF_ADDR_FLO && set_v == 24'h000000 |=> flags_r[7:0] == ($past(flags_r[7:0]) & $past(wr_val));
  endproperty
  a_and_low: assert property (p_and_low) else $error("flag write not an AND");

  property p_no_spurious_set;
    ##1 (flags_r & ~$past(flags_r) & ~$past(set_v)) == 24'h000000;
  endproperty
  a_no_spurious_set: assert property (p_no_spurious_set) else $error("flag rose without event");

  property p_set_wins;
    set_v != 24'h000000 |=> (flags_r & $past(set_v)) == ($past(set_v) & SSF_FLAG_IMPL);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_reserved_zero;
    flags_r[23:14] == 10'h000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bit set");

  property p_status_line;
    ##1 exception_status_line == ($past(|(flags_r & ext_exception_enable_mask)) && $past(basic_exception_enable_mask) == 8'h00);
  endproperty
  a_status_line: assert property (p_status_line) else $error("status line wrong");

  property p_join_reject;
    wr_fire && join_active && !is_halt |=> flags_r[SSF_BIT_WRREJ] && cmd_tx_byte == SSF_NACK;
  endproperty
  a_join_reject: assert property (p_join_reject) else $error("write accepted during pairing");

  property p_sec_answer;
    rd_fire && rd_addr == SSF_ADDR_SEC && rd_known |=> cmd_tx_valid && cmd_tx_byte == SSF_ACK &&
      resp_r == {SSF_ADDR_SEC, 5'h00, $past(nonvolatile_key_loaded), $past(volatile_key_loaded), 1'b0};
  endproperty
  a_sec_answer: assert property (p_sec_answer) else $error("security status answer wrong");

  property p_rx_clear;
    (rx_all_drained || clear_input_buffer_cmd_evt) && !rx_data_arrived |=> !flags_r[SSF_BIT_RXWAIT];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive pending not cleared");

  c_flag_write: cover property (wr_fire && wr_ok && is_flag);
  c_halt: cover property (wr_fire && is_halt && join_active);
  c_line: cover property (!exception_status_line ##1 exception_status_line);
  c_set_vs_clear: cover property (wr_fire && is_flag && set_v != 24'h000000);

endmodule
`default_nettype wire

// ### rtl/ssf_pkg.sv
// constants and carrier types for the security status and exception flag block
`default_nettype none
package ssf_pkg;
  // command framing on the byte stream
  localparam logic [7:0] SSF_HDR        = 8'hFF;
  localparam logic [7:0] SSF_ESC        = 8'hFE;
  localparam logic [7:0] SSF_ACK        = 8'h06;
  localparam logic [7:0] SSF_NACK       = 8'h15;
  localparam logic [7:0] SSF_SIZE_SUB   = 8'h04;
  localparam logic [7:0] SSF_VOL_BIT    = 8'h80;
  // volatile register addresses
  localparam logic [7:0] SSF_ADDR_SEC   = 8'hC9;
  localparam logic [7:0] SSF_ADDR_JOIN  = 8'hCA;
  localparam logic [7:0] SSF_ADDR_FHI   = 8'hCD;
  localparam logic [7:0] SSF_ADDR_FMID  = 8'hCE;
  localparam logic [7:0] SSF_ADDR_FLO   = 8'hCF;
  localparam logic [7:0] SSF_ADDR_CMD   = 8'hC7;
  // command register values
  localparam logic [7:0] SSF_CMD_CLEAR_INPUT_BUFFER_CMD  = 8'h07;
  localparam logic [7:0] SSF_CMD_JOIN   = 8'h10;
  localparam logic [7:0] SSF_JOIN_HALT  = 8'h00;
  // security status bit positions
  localparam int SSF_SEC_VKEY_BIT       = 1;
  localparam int SSF_SEC_NVKEY_BIT      = 2;
  // flag bit positions in the 24-bit flag word (low byte is bits 7:0)
  localparam int SSF_BIT_WRREJ          = 2;
  localparam int SSF_BIT_TXDONE         = 8;
  localparam int SSF_BIT_RXWAIT         = 9;
  localparam int SSF_BIT_PLAIN          = 10;
  localparam int SSF_BIT_SEQBACK        = 11;
  localparam int SSF_BIT_SEQGAP         = 12;
  localparam int SSF_BIT_JOIN           = 13;
  // implemented flag bits; the rest are reserved and read zero
  localparam logic [23:0] SSF_FLAG_IMPL = 24'h003FFF;
  localparam logic [23:0] SSF_FLAG_RST  = 24'h000000;
  // one-cycle event pulses of the low flag byte, packed in bit order 7..0
  typedef struct packed {
    logic frame_kind_error;
    logic ack_sequence_error;
    logic header_check_error;
    logic payload_check_error;
    logic ack_missing;
    logic write_rejected;
    logic radio_overflow;
    logic uart_overflow;
  } ssf_event_t;
  typedef enum {ST_IDLE, ST_SIZE, ST_ESC, ST_KIND, ST_RADDR, ST_WVAL, ST_WSUB, ST_RESP} ssf_state_t;
endpackage
`default_nettype wire

// ### bench/ssf_host.sv
// host side model: sends command frames and takes the answer bytes
`default_nettype none
module ssf_host
  import ssf_pkg::*;
(
  input  wire logic       clock,
  output logic      [7:0] cmd_rx_byte,
  output logic            cmd_rx_valid,
  input  wire logic [7:0] cmd_tx_byte,
  input  wire logic       cmd_tx_valid,
  output logic            cmd_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       slow = 1'b0;
  logic [7:0] resp[$];
  initial begin
    cmd_rx_byte = 8'h00;
    cmd_rx_valid = 1'b0;
    cmd_tx_ready = 1'b0;
  end
  // whole frame back to back, then up to n answer bytes; slow thins ready
  task automatic send(input logic [7:0] fr[$], input int n);
    int guard;
    resp.delete();
    guard = 0;
    foreach (fr[i]) begin
      @(negedge clock);
      cmd_rx_byte = fr[i];
      cmd_rx_valid = 1'b1;
    end
    @(negedge clock);
    cmd_rx_valid = 1'b0;
    // idle byte is inverted so a stale value can never look valid
    cmd_rx_byte = ~cmd_rx_byte;
    while (resp.size() < n && guard < 100) begin
      @(negedge clock);
      cmd_tx_ready = slow ? ~cmd_tx_ready : 1'b1;
      @(posedge clock);
      if (cmd_tx_valid === 1'b1 && cmd_tx_ready === 1'b1) resp.push_back(cmd_tx_byte);
      guard++;
    end
    @(negedge clock);
    cmd_tx_ready = 1'b0;
    while (cmd_tx_valid === 1'b1 && guard < 100) begin
      @(negedge clock);
      guard++;
    end
    @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ### bench/ssf_flags_tb.sv
// self-checking bench for the security status and exception flag block
`default_nettype none
module ssf_flags_tb
  import ssf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  cmd_rx_byte, cmd_tx_byte, join_activity_code, basic_exception_enable_mask;
  logic        cmd_rx_valid, cmd_tx_valid, cmd_tx_ready, exception_status_line;
  logic        tx_sent, tx_ack_required, ack_received, rx_data_arrived, rx_all_drained;
  logic        rx_plaintext_pkt, plaintext_receive_enable, rx_encrypted_pkt, join_start, join_finished;
  logic        volatile_key_loaded, nonvolatile_key_loaded, input_buffer_clear, join_halt, join_active;
  logic [15:0] rx_seq_num;
  logic [23:0] ext_exception_enable_mask;
  logic [23:0] mflags = 24'h000000;
  ssf_event_t  events;
  int          seed = 32'hc423;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          clr_cnt = 0;
  int          halt_cnt = 0;
  logic [7:0]  v;

  always #2 clock = ~clock;

  ssf_flags #(.SEQ_W(16)) dut (.clock(clock), .rst(rst), .cmd_rx_byte(cmd_rx_byte), .cmd_rx_valid(cmd_rx_valid),
    .cmd_tx_byte(cmd_tx_byte), .cmd_tx_valid(cmd_tx_valid), .cmd_tx_ready(cmd_tx_ready), .events(events),
    .tx_sent(tx_sent), .tx_ack_required(tx_ack_required), .ack_received(ack_received),
    .rx_data_arrived(rx_data_arrived), .rx_all_drained(rx_all_drained), .rx_plaintext_pkt(rx_plaintext_pkt),
    .plaintext_receive_enable(plaintext_receive_enable), .rx_encrypted_pkt(rx_encrypted_pkt),
    .rx_seq_num(rx_seq_num), .join_start(join_start), .join_finished(join_finished),
    .volatile_key_loaded(volatile_key_loaded), .nonvolatile_key_loaded(nonvolatile_key_loaded),
    .join_activity_code(join_activity_code), .ext_exception_enable_mask(ext_exception_enable_mask),
    .basic_exception_enable_mask(basic_exception_enable_mask), .exception_status_line(exception_status_line),
    .input_buffer_clear(input_buffer_clear), .join_halt(join_halt), .join_active(join_active));

  ssf_host host (.clock(clock), .cmd_rx_byte(cmd_rx_byte), .cmd_rx_valid(cmd_rx_valid),
    .cmd_tx_byte(cmd_tx_byte), .cmd_tx_valid(cmd_tx_valid), .cmd_tx_ready(cmd_tx_ready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.send('{8'hFF, 8'h03, 8'hFE, 8'hFE, a & 8'h7F}, 3);
    chk("read ack", SSF_ACK, host.resp[0]);
    chk("read address", a, host.resp[1]);
    chk("read value", e, host.resp[2]);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    host.send('{8'hFF, 8'h03, 8'hFE, a & 8'h7F, d}, 1);
    chk("write answer", e, host.resp[0]);
  endtask

  task automatic enc(input logic [15:0] s);
    @(negedge clock);
    rx_seq_num = s;
    rx_encrypted_pkt = 1'b1;
    @(negedge clock) rx_encrypted_pkt = 1'b0;
  endtask

  // mask inputs are levels, so the line is judged only after the flag pipeline settles
  task automatic line_chk(input logic [23:0] m, input logic [7:0] b);
    @(negedge clock);
    ext_exception_enable_mask = m;
    basic_exception_enable_mask = b;
    repeat (3) @(negedge clock);
    chk("status line", {7'h00, (|(mflags & m)) && b == 8'h00}, {7'h00, exception_status_line});
  endtask

  always @(posedge clock) begin
    cycles++;
    if (input_buffer_clear === 1'b1) clr_cnt++;
    if (join_halt === 1'b1) halt_cnt++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {tx_sent, tx_ack_required, ack_received, rx_data_arrived, rx_all_drained, rx_plaintext_pkt} = 6'h00;
    {plaintext_receive_enable, rx_encrypted_pkt, join_start, join_finished} = 4'h0;
    {volatile_key_loaded, nonvolatile_key_loaded, join_activity_code, rx_seq_num} = 26'h0000000;
    ext_exception_enable_mask = 24'h000000;
    basic_exception_enable_mask = 8'h00;
    events = '0;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    for (int k = 0; k < 4; k++) begin
      {nonvolatile_key_loaded, volatile_key_loaded} = k[1:0];
      rd(SSF_ADDR_SEC, {5'h00, k[1:0], 1'b0});
    end
    join_activity_code = 8'($random(seed));
    rd(SSF_ADDR_JOIN, join_activity_code);
    rd(SSF_ADDR_FHI, 8'h00);
    rd(SSF_ADDR_FMID, 8'h00);
    host.send('{8'hFF, 8'h03, 8'hFE, 8'hFE, 8'h40}, 1);
    chk("unmapped read", SSF_NACK, host.resp[0]);
    $display("test status reads done");
    for (int i = 0; i < 8; i++) begin
      @(negedge clock) events = ssf_event_t'(8'h01 << i);
      @(negedge clock) events = '0;
      mflags[i] = 1'b1;
      rd(SSF_ADDR_FLO, mflags[7:0]);
    end
    line_chk(24'h000000, 8'h00);
    line_chk(24'($random(seed)) | 24'h000001, 8'h00);
    line_chk(24'hFFFFFF, 8'($random(seed)) | 8'h01);
    rd(SSF_ADDR_FLO, mflags[7:0]);
    v = 8'($random(seed));
    wr(SSF_ADDR_FLO, v, SSF_ACK);
    mflags[7:0] &= v;
    rd(SSF_ADDR_FLO, mflags[7:0]);
    wr(SSF_ADDR_FLO, 8'hFF, SSF_ACK);
    rd(SSF_ADDR_FLO, mflags[7:0]);
    wr(SSF_ADDR_FHI, 8'hFF, SSF_ACK);
    rd(SSF_ADDR_FHI, 8'h00);
    wr(SSF_ADDR_JOIN, 8'h00, SSF_NACK);
    mflags[SSF_BIT_WRREJ] = 1'b1;
    rd(SSF_ADDR_FLO, mflags[7:0]);
    $display("test low flag byte done");
    host.slow = 1'b1;
    @(negedge clock) tx_sent = 1'b1;
    @(negedge clock) tx_sent = 1'b0;
    mflags[8] = 1'b1;
    rd(SSF_ADDR_FMID, mflags[15:8]);
    wr(SSF_ADDR_FMID, 8'h00, SSF_ACK);
    mflags[15:8] = 8'h00;
    tx_ack_required = 1'b1;
    @(negedge clock) tx_sent = 1'b1;
    @(negedge clock) tx_sent = 1'b0;
    rd(SSF_ADDR_FMID, mflags[15:8]);
    @(negedge clock) ack_received = 1'b1;
    @(negedge clock) ack_received = 1'b0;
    mflags[8] = 1'b1;
    rd(SSF_ADDR_FMID, mflags[15:8]);
    @(negedge clock) rx_data_arrived = 1'b1;
    @(negedge clock) rx_data_arrived = 1'b0;
    mflags[9] = 1'b1;
    rd(SSF_ADDR_FMID, mflags[15:8]);
    @(negedge clock) rx_all_drained = 1'b1;
    @(negedge clock) rx_all_drained = 1'b0;
    mflags[9] = 1'b0;
    rd(SSF_ADDR_FMID, mflags[15:8]);
    for (int p = 0; p < 2; p++) begin
      @(negedge clock) plaintext_receive_enable = p[0];
      @(negedge clock) rx_plaintext_pkt = 1'b1;
      @(negedge clock) rx_plaintext_pkt = 1'b0;
      mflags[10] = p[0];
      rd(SSF_ADDR_FMID, mflags[15:8]);
    end
    enc(16'h0005);
    enc(16'h0003);
    mflags[11] = 1'b1;
    rd(SSF_ADDR_FMID, mflags[15:8]);
    enc(16'h0006);
    mflags[12] = 1'b1;
    rd(SSF_ADDR_FMID, mflags[15:8]);
    wr(SSF_ADDR_FMID, 8'h00, SSF_ACK);
    mflags[15:8] = 8'h00;
    enc(16'h0007);
    rd(SSF_ADDR_FMID, 8'h00);
    @(negedge clock) rx_data_arrived = 1'b1;
    @(negedge clock) rx_data_arrived = 1'b0;
    wr(SSF_ADDR_CMD, SSF_CMD_CLEAR_INPUT_BUFFER_CMD, SSF_ACK);
    rd(SSF_ADDR_FMID, 8'h00);
    chk("buffer clear pulses", 8'h01, 8'(clr_cnt));
    $display("test middle flag byte done");
    @(negedge clock) join_start = 1'b1;
    @(negedge clock) join_start = 1'b0;
    mflags[13] = 1'b1;
    chk("join active", 8'h01, {7'h00, join_active});
    rd(SSF_ADDR_FMID, mflags[15:8]);
    wr(SSF_ADDR_FLO, 8'h00, SSF_NACK);
    mflags[SSF_BIT_WRREJ] = 1'b1;
    rd(SSF_ADDR_FLO, mflags[7:0]);
    host.send('{8'hFF, 8'h04, 8'hFE, 8'h47, SSF_CMD_JOIN, SSF_JOIN_HALT}, 1);
    chk("halt answer", SSF_ACK, host.resp[0]);
    chk("halt pulses", 8'h01, 8'(halt_cnt));
    @(negedge clock) join_finished = 1'b1;
    @(negedge clock) join_finished = 1'b0;
    chk("join idle", 8'h00, {7'h00, join_active});
    wr(SSF_ADDR_FLO, 8'h00, SSF_ACK);
    mflags[7:0] = 8'h00;
    // the clear lands on the same edge as a fresh event; the event must survive
    fork
      wr(SSF_ADDR_FLO, 8'h00, SSF_ACK);
      begin
        repeat (5) @(negedge clock);
        events = ssf_event_t'(8'h01);
        @(negedge clock) events = '0;
      end
    join
    mflags[0] = 1'b1;
    rd(SSF_ADDR_FLO, mflags[7:0]);
    $display("test join and priority done");
    complete_run();
  end
endmodule
`default_nettype wire
